// file: hw/ldfs_pkg.sv
// Package: constants and carrier types for the LED dimming fault supervisor
package ldfs_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int NUM_CH = 8;
    // Soft-start step period
    localparam int SS_STEP_MS = 2;
    localparam int SS_STEP_CYC = (CLK_HZ / 1000) * SS_STEP_MS;
    localparam int SS_STEPS = 8;
    localparam logic [3:0] SS_LEVEL_RST = 4'h1;
    localparam logic [3:0] SS_LEVEL_FULL = 4'h9;
    // Fault time-out in dimming cycles
    localparam logic [2:0] FAULT_TO_CYC = 3'h6;
    localparam logic [3:0] MAX_SHORT_OFF = 4'h3;
    // Dimming rate window: 100 Hz .. 30 kHz
    localparam int PWM_MIN_HZ = 100;
    localparam int PWM_MAX_HZ = 30000;
    localparam int PWM_MAX_PER_CYC = CLK_HZ / PWM_MIN_HZ;
    // Register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_GOOD = 4'h8;
    localparam logic [3:0] REG_OFF = 4'hc;
    localparam int CTRL_LED_EN_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    // Analog indications per channel, already synchronised
    typedef struct packed {
        logic [NUM_CH-1:0] at_target;
        logic [NUM_CH-1:0] below_target;
        logic [NUM_CH-1:0] over_short;
    } ldfs_chan_s;

    typedef enum logic [1:0] {
        LDFS_CH_IDLE = 2'b00,
        LDFS_CH_GOOD = 2'b01,
        LDFS_CH_OPEN = 2'b10,
        LDFS_CH_OFF = 2'b11
    } ldfs_ch_e;
endpackage

// file: hw/ldfs_top.sv
// Digital supervision of an eight-channel LED backlight driver
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module ldfs_top
    import ldfs_pkg::*;
#(
    parameter int STEP_CYC = SS_STEP_CYC
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Pins from outside the clock domain
    input wire logic pwm_dim_i,
    input wire logic enable_i,
    input wire logic input_undervoltage_reset_i,
    input wire logic output_overvoltage_limit_i,
    input wire logic temp_lower_i,
    input wire logic temp_upper_i,
    input wire logic [NUM_CH-1:0] chan_at_target_i,
    input wire logic [NUM_CH-1:0] chan_below_target_i,
    input wire logic [NUM_CH-1:0] channel_short_detect_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // To analog side
    output logic [NUM_CH-1:0] sink_on_o,
    output logic [3:0] boost_limit_o,
    output logic boost_run_o
);
    // Three-stage synchronisers; a change counts when stages two and three agree
    localparam int NSYNC = 6 + 3 * NUM_CH;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] filt_q;
    logic [NSYNC-1:0] raw;
    assign raw = {pwm_dim_i, enable_i, input_undervoltage_reset_i,
                  output_overvoltage_limit_i, temp_lower_i, temp_upper_i,
                  chan_at_target_i, chan_below_target_i, channel_short_detect_i};

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end
        else
        begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Agreement filter reads stages two and three only
            filt_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
        end
    end

    logic pwm_s, en_s, uv_s, ovp_s, tlo_s, thi_s;
    ldfs_chan_s ch_s;
    assign {pwm_s, en_s, uv_s, ovp_s, tlo_s, thi_s} = filt_q[NSYNC-1 -: 6];
    assign ch_s = filt_q[3*NUM_CH-1:0];

    // Clear of channel states and all-off flag, stop of run: enable low or undervoltage
    logic wipe;
    assign wipe = !en_s || uv_s;

    // Software control and thermal latch
    logic [31:0] ctrl_q;
    logic therm_off_q;
    logic led_en;
    assign led_en = ctrl_q[CTRL_LED_EN_BIT];

    // Bus slave: one wait state, ack next cycle; dead while enable low
    logic bus_req;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && en_s;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || uv_s)
            ctrl_q <= CTRL_RST;
        else if (bus_req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0])
            ctrl_q[7:0] <= wb_dat_i[7:0];
    end

    // Upper thermal limit latches until power is cycled
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            therm_off_q <= 1'b0;
        else if (thi_s)
            therm_off_q <= 1'b1;
    end

    // Undervoltage lock: stays set until the enable pin is seen low, so
    // recovery of the input alone never restarts the boost
    logic uv_lock_q;
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            uv_lock_q <= 1'b0;
        else if (uv_s)
            uv_lock_q <= 1'b1;
        else if (!en_s)
            uv_lock_q <= 1'b0;
    end

    // Dimming edges give the time-out its clock
    logic pwm_d1_q;
    logic pwm_rise;
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            pwm_d1_q <= 1'b0;
        else
            pwm_d1_q <= pwm_s;
    end
    assign pwm_rise = pwm_s && !pwm_d1_q;

    logic run;
    assign run = !wipe && led_en && !therm_off_q && !uv_lock_q;

    // Soft-start stepping of the boost current limit
    logic [31:0] ss_cnt_q;
    logic [3:0] ss_lvl_q;
    logic conducted_q;
    logic [NUM_CH-1:0] sink_q;
    logic stable;
    assign stable = (ss_lvl_q == SS_LEVEL_FULL);

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || !run)
        begin
            ss_cnt_q <= '0;
            ss_lvl_q <= SS_LEVEL_RST;
            conducted_q <= 1'b0;
        end
        else if (ss_lvl_q != SS_LEVEL_FULL)
        begin
            if (|(sink_q & ch_s.at_target))
                conducted_q <= 1'b1;
            if (ss_cnt_q >= STEP_CYC - 1)
            begin
                // Step held until a channel has conducted
                if (conducted_q)
                begin
                    ss_lvl_q <= ss_lvl_q + 4'h1;
                    ss_cnt_q <= '0;
                    conducted_q <= 1'b0;
                end
            end
            else
                ss_cnt_q <= ss_cnt_q + 32'h1;
        end
    end

    // Per-channel classification and time-out
    ldfs_ch_e st_q [NUM_CH];
    logic [2:0] to_q [NUM_CH];
    logic [NUM_CH-1:0] off_vec;
    logic [NUM_CH-1:0] short_hit;
    logic [3:0] off_cnt;
    logic all_off_q;

    always_comb
    begin
        off_cnt = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            off_vec[i] = (st_q[i] == LDFS_CH_OFF);
            off_cnt = off_cnt + {3'h0, off_vec[i]};
            short_hit[i] = run && stable && !off_vec[i] && ch_s.over_short[i];
        end
    end

    // Short while at least three channels are already off turns off every sink and the boost run
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || wipe)
            all_off_q <= 1'b0;
        else if (|short_hit && off_cnt >= MAX_SHORT_OFF)
            all_off_q <= 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            always_ff @(posedge clk_sys_i)
            begin
                if (!rst_n_i || wipe)
                begin
                    st_q[g] <= LDFS_CH_IDLE;
                    to_q[g] <= '0;
                end
                else if (short_hit[g])
                    st_q[g] <= LDFS_CH_OFF;
                else
                begin
                    case (st_q[g])
                        LDFS_CH_IDLE:
                        begin
                            if (ch_s.at_target[g])
                                st_q[g] <= LDFS_CH_GOOD;
                            else if (stable && (ovp_s || (tlo_s && ch_s.below_target[g])))
                                st_q[g] <= LDFS_CH_OPEN;
                            to_q[g] <= '0;
                        end
                        LDFS_CH_GOOD:
                        begin
                            if (stable && ch_s.below_target[g] && sink_q[g])
                                st_q[g] <= LDFS_CH_OPEN;
                            to_q[g] <= '0;
                        end
                        LDFS_CH_OPEN:
                        begin
                            // Recovery before the time-out hides transients
                            if (ch_s.at_target[g])
                            begin
                                st_q[g] <= LDFS_CH_GOOD;
                                to_q[g] <= '0;
                            end
                            else if (pwm_rise)
                            begin
                                if (to_q[g] == FAULT_TO_CYC - 3'h1)
                                    st_q[g] <= LDFS_CH_OFF;
                                else
                                    to_q[g] <= to_q[g] + 3'h1;
                            end
                        end
                        LDFS_CH_OFF: st_q[g] <= LDFS_CH_OFF;
                        default: st_q[g] <= LDFS_CH_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // Outputs to the analog side
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            sink_q <= '0;
            boost_limit_o <= '0;
            boost_run_o <= 1'b0;
        end
        else
        begin
            sink_q <= (run && !all_off_q) ? ({NUM_CH{pwm_s}} & ~off_vec) : '0;
            boost_limit_o <= run ? ss_lvl_q : 4'h0;
            boost_run_o <= run && !all_off_q;
        end
    end
    assign sink_on_o = sink_q;

    // Register read path and ack
    logic [31:0] rd_d;
    always_comb
    begin
        rd_d = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (wb_adr_i == REG_GOOD)
                rd_d[i] = (st_q[i] == LDFS_CH_GOOD);
            if (wb_adr_i == REG_OFF)
                rd_d[i] = off_vec[i];
        end
        if (wb_adr_i == REG_CTRL)
            rd_d = {24'h0, ctrl_q[7:0]};
        if (wb_adr_i == REG_STATUS)
            rd_d = {20'h0, ss_lvl_q, 3'h0, all_off_q, therm_off_q, tlo_s, ovp_s, stable};
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rd_d : 32'h0;
        end
    end
endmodule

// file: sim/ldfs_led_model.sv
// Dimming source and LED string model for the supervisor bench
`timescale 1ns/1ps
module ldfs_led_model
    import ldfs_pkg::*;
#(
    parameter int PER = 5000
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [NUM_CH-1:0] sink_on_i,
    input wire logic [NUM_CH-1:0] open_i,
    input wire logic [NUM_CH-1:0] short_i,
    output logic pwm_o,
    output ldfs_chan_s chan_o
);
    int cnt_q;
    // Free-running dimming source; PER keeps the rate inside the window
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            cnt_q <= 0;
        else
            cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
        pwm_o <= rst_n_i && (cnt_q < PER / 2);
    end
    // Strings conduct only while sunk; an open one never reaches target
    assign chan_o.at_target = sink_on_i & ~open_i;
    assign chan_o.below_target = sink_on_i & open_i;
    assign chan_o.over_short = short_i; // Level, sunk or not
endmodule

// file: sim/ldfs_top_sva.sv
// Port checker for the LED dimming fault supervisor
`timescale 1ns/1ps
module ldfs_top_sva
    import ldfs_pkg::*;
#(
    parameter int STEP_CYC = SS_STEP_CYC
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic pwm_dim_i,
    input wire logic enable_i,
    input wire logic input_undervoltage_reset_i,
    input wire logic temp_upper_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NUM_CH-1:0] sink_on_o,
    input wire logic [3:0] boost_limit_o,
    input wire logic boost_run_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    int gap_q;
    // Edges since the limit last moved; catches steps that come early
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || $changed(boost_limit_o))
            gap_q <= 0;
        else
            gap_q <= gap_q + 1;
    end
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_start_ninth: assert property ($past(boost_limit_o) == 4'h0 && boost_limit_o != 4'h0
        |-> boost_limit_o == 4'h1) else $error("soft-start not at one ninth");
    a_step_one: assert property ($changed(boost_limit_o) && $past(boost_limit_o) != 4'h0
        && boost_limit_o != 4'h0 |-> boost_limit_o == $past(boost_limit_o) + 4'h1)
        else $error("limit step not one ninth");
    a_step_gap: assert property ($changed(boost_limit_o) && $past(boost_limit_o) != 4'h0
        && boost_limit_o != 4'h0 |-> gap_q >= STEP_CYC - 1) else $error("step too early");
    a_uv_stop: assert property (input_undervoltage_reset_i [*6]
        |=> !boost_run_o && boost_limit_o == 4'h0) else $error("boost runs in undervoltage");
    a_en_shut: assert property (!enable_i [*6] |=> !boost_run_o && sink_on_o == '0)
        else $error("active while disabled");
    a_hot_latch: assert property (temp_upper_i [*6]
        |=> (!boost_run_o && sink_on_o == '0) [*8]) else $error("hot shutdown not latched");
    a_sink_pwm: assert property (sink_on_o != '0 |-> $past(pwm_dim_i, 5))
        else $error("sink on without dimming input");
    c_full: cover property (boost_limit_o == 4'h9);
    c_part_off: cover property (sink_on_o != '0 && sink_on_o != '1);
    c_read: cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule

bind ldfs_top ldfs_top_sva #(.STEP_CYC(STEP_CYC)) ldfs_top_sva_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .pwm_dim_i(pwm_dim_i), .enable_i(enable_i),
    .input_undervoltage_reset_i(input_undervoltage_reset_i), .temp_upper_i(temp_upper_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sink_on_o(sink_on_o),
    .boost_limit_o(boost_limit_o), .boost_run_o(boost_run_o));

// file: sim/ldfs_top_test.sv
// Self-checking testbench of the LED dimming fault supervisor
`timescale 1ns/1ps
module ldfs_top_test
    import ldfs_pkg::*;
;
    localparam int STEP = 50;
    localparam int PER = 5000;
    typedef struct packed {logic [3:0] adr; logic we; logic [31:0] dat; logic [31:0] exp;} ldfs_row_s;
    logic clk_sys_i, rst_n_i, enable_i, uv_i, upper_i, tlo_i, cyc, stb, we, ack, pwm, run;
    logic [3:0] adr, lim;
    logic [31:0] dat, dat_o, rd;
    logic [7:0] sink, open_m, short_m;
    ldfs_chan_s chan;
    int err_total = 0;
    int checked = 0;
    int n;
    ldfs_row_s rows [7] = '{'{REG_CTRL, 0, 0, 1}, '{REG_STATUS, 0, 0, 32'h901},
        '{REG_GOOD, 0, 0, 32'hff}, '{REG_CTRL, 1, 32'hffff_ff81, 0}, '{REG_CTRL, 0, 0, 32'h81},
        '{4'h2, 1, 32'hffff_ffff, 0}, '{4'h2, 0, 0, 0}};
    ldfs_top #(.STEP_CYC(STEP)) ldfs_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .pwm_dim_i(pwm), .enable_i(enable_i), .input_undervoltage_reset_i(uv_i),
        .output_overvoltage_limit_i(1'b0), .temp_lower_i(tlo_i), .temp_upper_i(upper_i),
        .chan_at_target_i(chan.at_target), .chan_below_target_i(chan.below_target),
        .channel_short_detect_i(chan.over_short), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .sink_on_o(sink), .boost_limit_o(lim), .boost_run_o(run));
    ldfs_led_model #(.PER(PER)) ldfs_led_model_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .sink_on_i(sink), .open_i(open_m), .short_i(short_m), .pwm_o(pwm), .chan_o(chan));
    // Free-running 125 MHz clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s got %h", $time, m, got);
        end
    endtask
    // Classic cycle: held until ack is sampled, then one idle cycle
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk_sys_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        k = 0;
        do
        begin
            @(posedge clk_sys_i);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        rd = dat_o;
        {cyc, stb} <= 2'b00;
        if (k >= 50) err_total++;
        @(posedge clk_sys_i);
    endtask
    task automatic wait_lim(input logic [3:0] v);
        n = 0;
        while (lim !== v && n < 20000)
        begin
            @(posedge clk_sys_i);
            n++;
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence; long waits are whole or half dimming periods
    initial
    begin
        {rst_n_i, enable_i, uv_i, upper_i, tlo_i, cyc, stb, we, adr, dat} = '0;
        {open_m, short_m} = '0;
        enable_i = 1'b1;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        wait_lim(4'h1);
        wait_lim(4'h9);
        chk({31'h0, n >= 7 * STEP}, 1, "soft-start span");
        chk({28'h0, lim}, 32'h9, "full limit");
        $display("test soft-start done");
        foreach (rows[i])
        begin
            wb(rows[i].adr, rows[i].we, rows[i].dat);
            chk(rd, rows[i].exp, "register row");
        end
        $display("test registers done");
        open_m <= 8'h01;
        repeat (4 * PER) @(posedge clk_sys_i);
        wb(REG_OFF, 0, 0);
        chk(rd, 0, "off before time-out");
        repeat (3 * PER) @(posedge clk_sys_i);
        wb(REG_OFF, 0, 0);
        chk(rd, 1, "off after six periods");
        wb(REG_GOOD, 0, 0);
        chk(rd, 32'hfe, "others stay good");
        $display("test open string done");
        short_m <= 8'h06;
        repeat (20) @(posedge clk_sys_i);
        wb(REG_OFF, 0, 0);
        chk(rd, 32'h07, "short channels off");
        chk({31'h0, run}, 1, "boost still runs");
        short_m <= 8'h0e;
        repeat (2)
        begin
            repeat (PER / 2) @(posedge clk_sys_i);
            chk({24'h0, sink}, 0, "all sinks off");
        end
        chk({31'h0, run}, 0, "boost off");
        $display("test shorts done");
        {short_m, open_m, uv_i} <= '1;
        repeat (10) @(posedge clk_sys_i);
        {short_m, open_m, uv_i} <= '0;
        repeat (50) @(posedge clk_sys_i);
        chk({28'h0, lim}, 0, "idle after undervoltage");
        enable_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        enable_i <= 1'b1;
        open_m <= 8'h10;
        wait_lim(4'h1);
        chk({28'h0, lim}, 1, "restart at first step");
        wb(REG_OFF, 0, 0);
        chk(rd, 0, "channel state cleared");
        wb(REG_CTRL, 0, 0);
        chk(rd, CTRL_RST, "settings at default");
        $display("test undervoltage done");
        // Lower thermal limit opens the never-good string, then times it out
        wait_lim(4'h9);
        tlo_i <= 1'b1;
        repeat (7 * PER) @(posedge clk_sys_i);
        wb(REG_OFF, 0, 0);
        chk(rd, 32'h10, "weak string off at lower limit");
        wb(REG_GOOD, 0, 0);
        chk(rd, 32'hef, "good strings kept");
        {tlo_i, open_m} <= '0;
        $display("test lower thermal done");
        upper_i <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        upper_i <= 1'b0;
        repeat (50) @(posedge clk_sys_i);
        chk({31'h0, run}, 0, "hot latch holds");
        $display("test thermal done");
        print_verdict();
    end
    // Watchdog well past the expected run length
    initial
    begin
        repeat (90000) @(posedge clk_sys_i);
        err_total++;
        print_verdict();
    end
endmodule
